// file: rtl/ast_transceiver.sv
// async serial transceiver: registers, baud, transmit, fifo, pins
`timescale 1ns/1ps
module ast_transceiver
  import ast_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic txPinIn,
  output logic txPinOut,
  output logic txPinOe,
  input wire logic rxPinIn,
  output logic rxPinOut,
  output logic rxPinOe,
  output logic txIrqReq,
  output logic rxIrqReq
);
  // software-visible state
  logic [7:0] txStat_q; // transmit_status_control
  logic [7:0] rxStat_q; // receive_status_control, control part
  logic [7:0] baud_q; // baud_divider
  logic [8:0] txBuf_q; // transmit_buffer plus ninth bit
  logic [3:0] pinCtrl_q; // direction and latch of both pins
  logic [1:0] irqEn_q; // bit0 transmit, bit1 receive
  logic [7:0] rdData_q;
  logic [7:0] rdMux;
  // transmit state
  logic bufFull_q; // a character waits in the buffer
  logic bufLag_q; // delayed copy for the flag
  logic txBusy_q; // shifter holds a character
  logic [10:0] txShift_q; // transmit_shifter
  logic [3:0] txLeft_q; // frame bits still to send
  logic [3:0] txTick_q; // position inside a bit
  // baud generator
  logic [7:0] preCnt_q;
  logic [1:0] quarter_q;
  logic sampleTick_q;
  // receive fifo
  logic [9:0] fifoMem_q [2]; // {framing error, nine data bits}
  logic fifoRd_q;
  logic [1:0] fifoCnt_q;
  logic overrun_error_status_q; // overrun_error_status
  // pins
  logic [1:0] rxSync_q;
  logic [1:0] txSync_q;
  logic txPinOut_q, txPinOe_q, rxPinOut_q, rxPinOe_q;
  // decoded controls
  logic serial_port_enable, syncMode, txActive, rxActive, nineTx, nineRx;
  logic txWrite, txLoad, txBitEnd, txFlag, rxFlag;
  logic accept, push, pop, overrunEvt, wrIdx;
  logic [9:0] top;

  ast_rx_if rxLink ();

  // register port decode, used for every strobe
  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    return a == r;
  endfunction : hit

  assign serial_port_enable = rxStat_q[SERIAL_PORT_ENABLE_BIT];
  assign syncMode = txStat_q[SYNC_BIT];
  assign txActive = txStat_q[TRANSMIT_ENABLE_BIT] & !syncMode & serial_port_enable;
  assign rxActive = rxStat_q[CONTINUOUS_RECEIVE_ENABLE_BIT] & !syncMode & serial_port_enable;
  assign nineTx = txStat_q[TX9_BIT];
  assign nineRx = rxStat_q[RX9_BIT];
  assign txWrite = regWr & hit(regAddr, ADDR_TX_BUF);

  // control registers; status bits are not stored here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txStat_q <= TX_STAT_RESET & TX_STAT_WMASK;
      rxStat_q <= RX_STAT_RESET;
      baud_q <= BAUD_RESET;
      pinCtrl_q <= PIN_CTRL_RESET;
      irqEn_q <= 2'h0;
    end else if (regWr) begin
      if (hit(regAddr, ADDR_TX_STAT)) txStat_q <= regWrData & TX_STAT_WMASK;
      if (hit(regAddr, ADDR_RX_STAT)) rxStat_q <= regWrData & RX_STAT_WMASK;
      if (hit(regAddr, ADDR_BAUD)) baud_q <= regWrData;
      if (hit(regAddr, ADDR_PIN_CTRL)) pinCtrl_q <= regWrData[3:0];
      if (hit(regAddr, ADDR_IRQ_EN)) irqEn_q <= regWrData[1:0];
    end
  end

  // read mux; reserved bits and unmapped lanes read zero
  always_comb begin
    rdMux = 8'h00;
    unique case (regAddr)
      ADDR_TX_STAT: begin
        rdMux = txStat_q;
        rdMux[SHIFTER_EMPTY_STATUS_BIT] = !txBusy_q;
      end
      ADDR_RX_STAT: begin
        rdMux = rxStat_q;
        rdMux[FRAMING_ERROR_STATUS_BIT] = top[9];
        rdMux[OVERRUN_ERROR_STATUS_BIT] = overrun_error_status_q;
        rdMux[RECEIVE_NINTH_BIT_BIT] = top[8];
      end
      ADDR_BAUD: rdMux = baud_q;
      ADDR_TX_BUF: rdMux = 8'h00; // write only
      ADDR_RX_BUF: rdMux = top[7:0];
      ADDR_PIN_CTRL: begin
        rdMux[3:0] = pinCtrl_q;
        rdMux[TX_LEVEL_BIT] = txSync_q[1];
        rdMux[RX_LEVEL_BIT] = rxSync_q[1];
      end
      ADDR_IRQ_EN: rdMux[1:0] = irqEn_q;
      ADDR_IRQ_FLAG: rdMux[1:0] = {rxFlag, txFlag};
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdData_q <= 8'h00;
    else rdData_q <= regRd ? rdMux : 8'h00;
  end
  assign regRdData = rdData_q;

  // baud generator: divider+1 clocks per tick, quartered at low speed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preCnt_q <= 8'h00;
      quarter_q <= 2'h0;
      sampleTick_q <= 1'b0;
    end else if (!serial_port_enable) begin
      preCnt_q <= baud_q;
      quarter_q <= 2'h0;
      sampleTick_q <= 1'b0;
    end else begin
      sampleTick_q <= 1'b0;
      if (preCnt_q == 8'h00) begin
        preCnt_q <= baud_q;
        quarter_q <= quarter_q + 2'h1;
        if (txStat_q[HIGH_SPEED_BAUD_SELECT_BIT] || quarter_q == LOW_SPEED_LAST) sampleTick_q <= 1'b1;
      end else begin
        preCnt_q <= preCnt_q - 8'h01;
      end
    end
  end

  // transmit buffer; a new write wins over the move out
  assign txLoad = txActive & bufFull_q & !txBusy_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txBuf_q <= TX_BUF_RESET;
      bufFull_q <= 1'b0;
    end else begin
      if (txWrite) txBuf_q <= {txStat_q[TRANSMIT_NINTH_BIT_BIT], regWrData};
      if (!txActive) bufFull_q <= 1'b0;
      else if (txWrite) bufFull_q <= 1'b1;
      else if (txLoad) bufFull_q <= 1'b0;
    end
  end

  // flag lags the buffer by one flop, so it is valid from the
  // second cycle after a write; polling sooner sees stale state.
  // a character that moves straight into an idle shifter never
  // waits, so it must not pull the flag low for a cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) bufLag_q <= 1'b0;
    else bufLag_q <= bufFull_q & !txLoad;
  end
  assign txFlag = txStat_q[TRANSMIT_ENABLE_BIT] & !bufLag_q;
  assign txIrqReq = txFlag & irqEn_q[0];

  // transmit shifter; shifts in marks so the line idles high
  assign txBitEnd = sampleTick_q && txTick_q == LAST_TICK;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txBusy_q <= 1'b0;
      txShift_q <= '1;
      txLeft_q <= 4'h0;
      txTick_q <= 4'h0;
    end else if (!txActive) begin
      // disabling aborts a character in flight
      txBusy_q <= 1'b0;
      txShift_q <= '1;
      txLeft_q <= 4'h0;
      txTick_q <= 4'h0;
    end else if (txLoad) begin
      // stop, optional ninth, data, start; no parity bit
      txShift_q <= {1'b1, nineTx ? txBuf_q[8] : 1'b1, txBuf_q[7:0], 1'b0};
      txLeft_q <= nineTx ? FRAME_BITS_9 : FRAME_BITS_8;
      txBusy_q <= 1'b1;
      txTick_q <= 4'h0;
    end else if (txBusy_q && sampleTick_q) begin
      txTick_q <= txTick_q + 4'h1;
      if (txBitEnd) begin
        txShift_q <= {1'b1, txShift_q[10:1]};
        txLeft_q <= txLeft_q - 4'h1;
        if (txLeft_q == 4'h1) txBusy_q <= 1'b0;
      end
    end
  end

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxSync_q <= 2'h3;
      txSync_q <= 2'h3;
    end else begin
      rxSync_q <= {rxSync_q[0], rxPinIn};
      txSync_q <= {txSync_q[0], txPinIn};
    end
  end

  // receiver; runs from the shared 16x tick
  ast_rx_recovery u_rx (
    .clk(clk),
    .rst(rst),
    .enable(rxActive),
    .nineBit(nineRx),
    .sampleTick(sampleTick_q),
    .rxLevel(rxSync_q[1]),
    .rxOut(rxLink.rcv)
  );

  // fifo control; a read frees a slot in the same cycle
  assign accept = rxLink.charValid & rxActive &
    (!rxStat_q[ADDRESS_DETECT_ENABLE_BIT] | !nineRx | rxLink.charData[8]);
  assign pop = regRd & hit(regAddr, ADDR_RX_BUF) & (fifoCnt_q != 2'h0);
  assign push = accept & !overrun_error_status_q & (fifoCnt_q != FIFO_DEPTH | pop);
  assign overrunEvt = accept & !overrun_error_status_q & fifoCnt_q == FIFO_DEPTH & !pop;
  assign wrIdx = fifoRd_q ^ (fifoCnt_q == 2'h1);
  assign top = fifoMem_q[fifoRd_q];

  // fifo storage; each entry keeps its own framing error
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifoMem_q[0] <= 10'h000;
      fifoMem_q[1] <= 10'h000;
    end else if (!serial_port_enable) begin
      fifoMem_q[0] <= 10'h000;
      fifoMem_q[1] <= 10'h000;
    end else if (push) begin
      fifoMem_q[wrIdx] <= {rxLink.charFerr, rxLink.charData};
    end
  end

  // fifo pointers; port disable empties it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifoRd_q <= 1'b0;
      fifoCnt_q <= 2'h0;
    end else if (!serial_port_enable) begin
      fifoRd_q <= 1'b0;
      fifoCnt_q <= 2'h0;
    end else begin
      if (pop) fifoRd_q <= !fifoRd_q;
      if (push && !pop) fifoCnt_q <= fifoCnt_q + 2'h1;
      else if (pop && !push) fifoCnt_q <= fifoCnt_q - 2'h1;
    end
  end

  // overrun: set wins; clearing receive or port enable, or setting sync mode, clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) overrun_error_status_q <= 1'b0;
    else if (overrunEvt) overrun_error_status_q <= 1'b1;
    else if (!rxActive) overrun_error_status_q <= 1'b0;
  end

  assign rxFlag = rxActive & (fifoCnt_q != 2'h0);
  assign rxIrqReq = rxFlag & irqEn_q[1];

  // pin drivers; port enable overrides direction and latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txPinOut_q <= 1'b1;
      txPinOe_q <= 1'b0;
      rxPinOut_q <= 1'b0;
      rxPinOe_q <= 1'b0;
    end else begin
      txPinOut_q <= serial_port_enable ? txShift_q[0] : pinCtrl_q[TX_LATCH_BIT];
      txPinOe_q <= serial_port_enable | !pinCtrl_q[TX_DIR_BIT];
      rxPinOut_q <= serial_port_enable ? 1'b0 : pinCtrl_q[RX_LATCH_BIT];
      rxPinOe_q <= !serial_port_enable & !pinCtrl_q[RX_DIR_BIT];
    end
  end
  assign txPinOut = txPinOut_q;
  assign txPinOe = txPinOe_q;
  assign rxPinOut = rxPinOut_q;
  assign rxPinOe = rxPinOe_q;

  // checks
  sequence bufWrittenBusy;
    txWrite && txActive && txBusy_q && !bufFull_q && txLeft_q > 4'h2;
  endsequence
  sequence flagLagThenClear;
    txFlag ##1 !txFlag;
  endsequence

  idle_mark_a: assert property (@(posedge clk) disable iff (rst)
    !txBusy_q |-> txShift_q[0]) else $error("line not at mark while idle");
  start_space_a: assert property (@(posedge clk) disable iff (rst)
    $rose(txBusy_q) |-> !txShift_q[0] && $past(bufFull_q))
    else $error("load did not begin with a start bit");
  bit_hold_a: assert property (@(posedge clk) disable iff (rst)
    $past(txBusy_q) && $past(txActive) && $changed(txShift_q) |-> $past(txBitEnd))
    else $error("line changed inside a bit period");
  tx_gate_a: assert property (@(posedge clk) disable iff (rst)
    !txActive |=> !txBusy_q && !bufFull_q) else $error("transmit ran while gated off");
  transmit_enable_flag_a: assert property (@(posedge clk) disable iff (rst)
    $rose(txStat_q[TRANSMIT_ENABLE_BIT]) && !bufLag_q |-> txFlag) else $error("flag not set with enable");
  flag_lag_a: assert property (@(posedge clk) disable iff (rst)
    bufWrittenBusy |=> flagLagThenClear) else $error("flag timing after write wrong");
  queue_move_a: assert property (@(posedge clk) disable iff (rst)
    $fell(txBusy_q) && txActive && bufFull_q |=> txBusy_q)
    else $error("queued character not moved within one cycle");
  pin_force_a: assert property (@(posedge clk) disable iff (rst)
    serial_port_enable [*2] |-> txPinOe && !rxPinOe) else $error("port enable did not steer pins");
  fifo_push_a: assert property (@(posedge clk) disable iff (rst)
    push && !pop && serial_port_enable |=> fifoCnt_q == $past(fifoCnt_q) + 2'h1)
    else $error("character not stored in fifo");
  overrun_set_a: assert property (@(posedge clk) disable iff (rst)
    overrunEvt |=> overrun_error_status_q && fifoCnt_q == FIFO_DEPTH) else $error("overrun not flagged");
  addr_drop_a: assert property (@(posedge clk) disable iff (rst)
    rxLink.charValid && rxStat_q[ADDRESS_DETECT_ENABLE_BIT] && nineRx && !rxLink.charData[8] |-> !push)
    else $error("non-address character stored");
endmodule : ast_transceiver

// file: rtl/ast_pkg.sv
// constants and types shared by the async serial transceiver
package ast_pkg;
  // Notes on behaviour
  // - line rests at mark, no return between bits
  // - start space, eight or nine data, mark stop
  // - each sent bit lasts one bit period
  // - one 8-bit baud generator feeds both directions
  // - data travel least significant bit first
  // - no hardware parity; ninth bit carries it
  // - transmit needs enable, async, port enable
  // - port enable forces transmit pin to output
  // - port enable forces receive pin to input
  // - setting transmit enable raises buffer-empty flag
  // - buffer write starts transfer into idle shifter
  // - queued character loads one cycle after stop
  // - empty flag clear only when transmit enable off, or busy and queued
  // - empty flag valid second cycle after write
  // - empty flag ignores enable; request needs it
  // - shifter empty status tracks shifter, no interrupt
  // - ninth bit written first, loads with buffer
  // - receive pin sampled sixteen times per bit
  // - finished character enters two-entry receive fifo
  // - receive needs enable, async, port enable
  // - start confirmed at half bit, majority sampling
  // - zero stop sample stores framing error
  // - third character with full fifo sets overrun
  // - address mode keeps only ninth-bit characters

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int INSTR_CYCLE_NS = 20;
  localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // register indices on the local port
  localparam logic [2:0] ADDR_TX_STAT = 3'h0;
  localparam logic [2:0] ADDR_RX_STAT = 3'h1;
  localparam logic [2:0] ADDR_BAUD = 3'h2;
  localparam logic [2:0] ADDR_TX_BUF = 3'h3;
  localparam logic [2:0] ADDR_RX_BUF = 3'h4;
  localparam logic [2:0] ADDR_PIN_CTRL = 3'h5;
  localparam logic [2:0] ADDR_IRQ_EN = 3'h6;
  localparam logic [2:0] ADDR_IRQ_FLAG = 3'h7;
  // transmit_status_control fields
  localparam int TX9_BIT = 6;
  localparam int TRANSMIT_ENABLE_BIT = 5;
  localparam int SYNC_BIT = 4;
  localparam int HIGH_SPEED_BAUD_SELECT_BIT = 2;
  localparam int SHIFTER_EMPTY_STATUS_BIT = 1;
  localparam int TRANSMIT_NINTH_BIT_BIT = 0;
  localparam logic [7:0] TX_STAT_WMASK = 8'hf5;
  // receive_status_control fields
  localparam int SERIAL_PORT_ENABLE_BIT = 7;
  localparam int RX9_BIT = 6;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int ADDRESS_DETECT_ENABLE_BIT = 3;
  localparam int FRAMING_ERROR_STATUS_BIT = 2;
  localparam int OVERRUN_ERROR_STATUS_BIT = 1;
  localparam int RECEIVE_NINTH_BIT_BIT = 0;
  localparam logic [7:0] RX_STAT_WMASK = 8'hf8;
  // pin control fields, 1 in a direction bit means input
  localparam int TX_DIR_BIT = 0;
  localparam int RX_DIR_BIT = 1;
  localparam int TX_LATCH_BIT = 2;
  localparam int RX_LATCH_BIT = 3;
  localparam int TX_LEVEL_BIT = 4;
  localparam int RX_LEVEL_BIT = 5;
  // reset values
  localparam logic [7:0] TX_STAT_RESET = 8'h02;
  localparam logic [7:0] RX_STAT_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [8:0] TX_BUF_RESET = 9'h000;
  localparam logic [3:0] PIN_CTRL_RESET = 4'h3;
  // oversampling and framing
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [3:0] VOTE_A = 4'h7;
  localparam logic [3:0] VOTE_B = 4'h8;
  localparam logic [3:0] VOTE_C = 4'h9;
  localparam logic [1:0] LOW_SPEED_LAST = 2'h3;
  localparam logic [3:0] FRAME_BITS_8 = 4'ha;
  localparam logic [3:0] FRAME_BITS_9 = 4'hb;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef enum {AST_RX_IDLE, AST_RX_START, AST_RX_DATA, AST_RX_STOP} ast_rx_state_t;
endpackage : ast_pkg

// file: rtl/ast_rx_if.sv
// link from receive data recovery to the receive fifo
`timescale 1ns/1ps
interface ast_rx_if;
  logic charValid; // one-cycle pulse, character complete
  logic [8:0] charData; // received bits, ninth on top
  logic charFerr; // stop bit sampled as space
  modport rcv (output charValid, output charData, output charFerr);
  modport core (input charValid, input charData, input charFerr);
endinterface : ast_rx_if

// file: rtl/ast_rx_recovery.sv
// receive data recovery: start detect, majority vote, shifter
`timescale 1ns/1ps
module ast_rx_recovery
  import ast_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic nineBit,
  input wire logic sampleTick,
  input wire logic rxLevel,
  ast_rx_if.rcv rxOut
);
  ast_rx_state_t state_q; // recovery state
  logic [3:0] tick_q; // position inside a bit
  logic [3:0] bits_q; // data bits taken
  logic [8:0] shift_q; // receive_shifter
  logic [1:0] votes_q; // first two votes
  logic prev_q; // last sample, for edge find
  logic valid_q;
  logic [8:0] data_q;
  logic framing_error_status_q;
  logic vote;

  // majority of three samples around the bit centre
  function automatic logic vote3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : vote3

  assign vote = vote3(votes_q[0], votes_q[1], rxLevel);

  // one sequencer; abandons at once when disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= AST_RX_IDLE;
      tick_q <= 4'h0;
      bits_q <= 4'h0;
      shift_q <= 9'h000;
      votes_q <= 2'h0;
      prev_q <= 1'b1;
      valid_q <= 1'b0;
      data_q <= 9'h000;
      framing_error_status_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      if (sampleTick) prev_q <= rxLevel;
      if (!enable) begin
        state_q <= AST_RX_IDLE;
      end else if (sampleTick) begin
        tick_q <= tick_q + 4'h1;
        if (tick_q == VOTE_A) votes_q[0] <= rxLevel;
        if (tick_q == VOTE_B) votes_q[1] <= rxLevel;
        unique case (state_q)
          AST_RX_IDLE: begin
            // falling edge: this sample is tick zero
            if (prev_q && !rxLevel) begin
              state_q <= AST_RX_START;
              tick_q <= 4'h1;
            end
          end
          AST_RX_START: begin
            // still low at the centre, or quietly give up
            if (tick_q == VOTE_C) begin
              state_q <= vote ? AST_RX_IDLE : AST_RX_DATA;
              bits_q <= 4'h0;
            end
          end
          AST_RX_DATA: begin
            if (tick_q == VOTE_C) begin
              shift_q <= {vote, shift_q[8:1]};
              bits_q <= bits_q + 4'h1;
              if (bits_q + 4'h1 == (nineBit ? DATA_BITS_9 : DATA_BITS_8)) begin
                state_q <= AST_RX_STOP;
              end
            end
          end
          AST_RX_STOP: begin
            if (tick_q == VOTE_C) begin
              state_q <= AST_RX_IDLE;
              valid_q <= 1'b1;
              data_q <= nineBit ? shift_q : {1'b0, shift_q[8:1]};
              framing_error_status_q <= !vote;
            end
          end
        endcase
      end
    end
  end

  assign rxOut.charValid = valid_q;
  assign rxOut.charData = data_q;
  assign rxOut.charFerr = framing_error_status_q;

  // a character only completes while enabled
  rx_enable_a: assert property (@(posedge clk) disable iff (rst)
    valid_q |-> $past(enable)) else $error("character completed while disabled");
endmodule : ast_rx_recovery

// file: sim/ast_serial_node.sv
// remote serial node: drives the receive line, decodes the transmit line
`timescale 1ns/1ps
module ast_serial_node #(
  parameter int BIT_CLKS = 16, // clocks per bit at divider 0, high speed
  parameter int WAIT_CLKS = 2000 // give up on a frame after this
) (
  input wire logic clk,
  input wire logic txLine,
  output logic rxLine
);
  // idle at mark, as a pulled-up line would
  initial rxLine = 1'b1;
  // one frame: space start, data lsb first, chosen stop level
  task automatic sendChar(input logic [8:0] data, input int nBits, input logic stopLvl);
    int i;
    @(posedge clk);
    rxLine <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (i = 0; i < nBits; i++) begin
      rxLine <= data[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxLine <= stopLvl;
    repeat (BIT_CLKS) @(posedge clk);
    rxLine <= 1'b1;
  endtask : sendChar
  // short space, too short to pass the half-bit start check
  task automatic glitch(input int n);
    @(posedge clk);
    rxLine <= 1'b0;
    repeat (n) @(posedge clk);
    rxLine <= 1'b1;
  endtask : glitch
  // decode a frame at bit centres; ok low if none came
  task automatic recvChar(input int nBits, output logic [8:0] data, output logic stopLvl,
    output logic ok);
    int i;
    int w;
    data = 9'h000;
    ok = 1'b0;
    stopLvl = 1'b0;
    w = 0;
    while (txLine !== 1'b0 && w < WAIT_CLKS) begin
      @(posedge clk);
      w++;
    end
    if (w >= WAIT_CLKS) return;
    repeat (BIT_CLKS / 2) @(posedge clk);
    if (txLine !== 1'b0) return;
    for (i = 0; i < nBits; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      data[i] = txLine;
    end
    repeat (BIT_CLKS) @(posedge clk);
    stopLvl = txLine;
    ok = 1'b1;
  endtask : recvChar
endmodule : ast_serial_node

// file: sim/ast_transceiver_tb.sv
// self-checking bench for the async serial transceiver
`timescale 1ns/1ps
module ast_transceiver_tb;
  import ast_pkg::*;
  logic clk;
  logic rst;
  logic [2:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  logic txPinOut;
  logic txPinOe;
  logic rxLine;
  logic rxPinOut;
  logic rxPinOe;
  logic txIrqReq;
  logic rxIrqReq;
  int bad_count = 0;
  int cmp_count = 0;
  logic [8:0] d1;
  logic [8:0] d2;
  logic s1;
  logic s2;
  logic k1;
  logic k2;

  ast_transceiver ast_transceiver_i (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .txPinIn(txPinOut), .txPinOut(txPinOut), .txPinOe(txPinOe), .rxPinIn(rxLine),
    .rxPinOut(rxPinOut), .rxPinOe(rxPinOe), .txIrqReq(txIrqReq), .rxIrqReq(rxIrqReq));
  ast_serial_node ast_serial_node_i (.clk(clk), .txLine(txPinOut), .rxLine(rxLine));

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // compare and count; mismatch reported at once
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      bad_count++;
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // one-cycle read strobe, data taken in the following cycle only
  task automatic rdChk(input logic [2:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk({1'b0, regRdData}, {1'b0, exp}, msg);
  endtask : rdChk
  // verdict and end of run
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // reset values and pin state before the port is on
  task automatic testReset;
    rdChk(ADDR_TX_STAT, 8'h02, "tx status reset");
    rdChk(ADDR_BAUD, 8'h00, "baud reset");
    chk({8'h00, txPinOe}, 9'h000, "tx pin released");
    // both pins as outputs, tx latch low, rx latch high
    wr(ADDR_PIN_CTRL, 8'h08);
    repeat (2) @(posedge clk);
    #1;
    chk({5'h00, txPinOe, txPinOut, rxPinOe, rxPinOut}, 9'h00b, "latches drive");
    wr(ADDR_BAUD, 8'h00);
    wr(ADDR_RX_STAT, 8'h90);
    repeat (2) @(posedge clk);
    #1;
    chk({5'h00, txPinOe, txPinOut, rxPinOe, rxPinOut}, 9'h00c, "pins forced");
    wr(ADDR_TX_STAT, 8'h24);
    rdChk(ADDR_IRQ_FLAG, 8'h01, "enable sets empty flag");
    chk({8'h00, txIrqReq}, 9'h000, "no request while masked");
    wr(ADDR_IRQ_EN, 8'h03);
    #1;
    chk({8'h00, txIrqReq}, 9'h001, "request when enabled");
    $display("test reset done");
  endtask : testReset
  // two back-to-back characters, second one queued
  task automatic testTxPair;
    fork
      begin
        ast_serial_node_i.recvChar(8, d1, s1, k1);
        ast_serial_node_i.recvChar(8, d2, s2, k2);
      end
      begin
        wr(ADDR_TX_BUF, 8'ha5);
        wr(ADDR_TX_BUF, 8'h3c);
        rdChk(ADDR_IRQ_FLAG, 8'h00, "flag clear, one queued");
        chk({8'h00, txIrqReq}, 9'h000, "request drops");
        rdChk(ADDR_TX_STAT, 8'h24, "shifter busy");
      end
    join
    chk({k1, d1[7:0]}, 9'h1a5, "first char");
    chk({k2, d2[7:0]}, 9'h13c, "second char");
    chk({7'h00, s1, s2}, 9'h003, "stop bits mark");
    repeat (16) @(posedge clk);
    rdChk(ADDR_TX_STAT, 8'h26, "shifter empty again");
    rdChk(ADDR_IRQ_FLAG, 8'h01, "flag set again");
    // message over: software drops the transmit enable of the request
    wr(ADDR_IRQ_EN, 8'h02);
    #1;
    chk({8'h00, txIrqReq}, 9'h000, "request masked");
    $display("test tx pair done");
  endtask : testTxPair
  // nine-bit character, ninth bit written first
  task automatic testTxNine;
    wr(ADDR_TX_STAT, 8'h65);
    fork
      ast_serial_node_i.recvChar(9, d1, s1, k1);
      wr(ADDR_TX_BUF, 8'h55);
    join
    chk(d1, 9'h155, "nine bit char");
    wr(ADDR_TX_STAT, 8'h04);
    wr(ADDR_TX_BUF, 8'h0f);
    ast_serial_node_i.recvChar(8, d1, s1, k1);
    chk({8'h00, k1}, 9'h000, "disabled tx stays idle");
    wr(ADDR_TX_STAT, 8'h24);
    $display("test tx nine done");
  endtask : testTxNine
  // three characters with no reads, then drain
  task automatic testRxOverrun;
    ast_serial_node_i.sendChar(9'h081, 8, 1'b1);
    ast_serial_node_i.sendChar(9'h042, 8, 1'b1);
    ast_serial_node_i.sendChar(9'h099, 8, 1'b1);
    repeat (4) @(posedge clk);
    chk({8'h00, rxIrqReq}, 9'h001, "receive request");
    rdChk(ADDR_RX_STAT, 8'h92, "overrun set");
    rdChk(ADDR_RX_BUF, 8'h81, "fifo first");
    rdChk(ADDR_RX_BUF, 8'h42, "fifo second");
    rdChk(ADDR_IRQ_FLAG, 8'h01, "fifo empty");
    wr(ADDR_RX_STAT, 8'h80);
    wr(ADDR_RX_STAT, 8'h90);
    rdChk(ADDR_RX_STAT, 8'h90, "overrun cleared");
    $display("test rx overrun done");
  endtask : testRxOverrun
  // bad stop bit, short glitch, address filter
  task automatic testRxErrors;
    ast_serial_node_i.sendChar(9'h03c, 8, 1'b0);
    repeat (4) @(posedge clk);
    rdChk(ADDR_RX_STAT, 8'h94, "framing error");
    rdChk(ADDR_RX_BUF, 8'h3c, "framed char kept");
    ast_serial_node_i.glitch(4);
    repeat (200) @(posedge clk);
    rdChk(ADDR_IRQ_FLAG, 8'h01, "glitch ignored");
    wr(ADDR_RX_STAT, 8'hd8);
    ast_serial_node_i.sendChar(9'h012, 9, 1'b1);
    repeat (4) @(posedge clk);
    rdChk(ADDR_IRQ_FLAG, 8'h01, "data char dropped");
    ast_serial_node_i.sendChar(9'h1a7, 9, 1'b1);
    repeat (4) @(posedge clk);
    rdChk(ADDR_RX_STAT, 8'hd9, "address ninth bit");
    rdChk(ADDR_RX_BUF, 8'ha7, "address char");
    $display("test rx errors done");
  endtask : testRxErrors

  // main sequence: inputs at zero, reset six cycles
  initial begin
    rst = 1'b1;
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    testReset();
    testTxPair();
    testTxNine();
    testRxOverrun();
    testRxErrors();
    final_report();
  end
  // watchdog, about thirteen times the expected run
  initial begin
    #1000000;
    bad_count++;
    final_report();
  end
endmodule : ast_transceiver_tb
